// ---- logic/calib_consts.svh ----
// Register indices, field positions and reset values of the calibration bank
// Functional notes
// - Multipoint enabled: extra Phase B current gain from a multipoint entry.
// - Multipoint disabled: Phase B phase compensation uses correction entry 0.
// - Multipoint enabled: phase compensation uses one of five correction entries.
// - Entry chosen by Phase B current rms against low and high thresholds.
// - Phase B current channel is scaled by the current gain register.
// - Phase B voltage channel is scaled by the voltage gain register.
// - Power gain scales all six Phase B power results.
// - Active power offset is added to Phase B total active power.
// - Phase B current and voltage rms each get their own offset.
// - Phase A fundamental current and voltage rms get their own offsets.
// - Phase A half-cycle voltage and current rms get their own offsets.
// - Phase A 10/12-cycle voltage and current rms get their own offsets.
`ifndef CALIB_CONSTS_SVH
`define CALIB_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define CAL_AW 12
`define CAL_DW 32
`define CAL_NSLOT 31
`define MP_ENTRIES 5
`define GAIN_FRAC 27

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_PHA_FIRMS_OS 12'h013
`define IDX_PHA_FVRMS_OS 12'h014
`define IDX_PHA_HVRMS_OS 12'h015
`define IDX_PHA_HIRMS_OS 12'h016
`define IDX_PHA_MVRMS_OS 12'h017
`define IDX_PHA_MIRMS_OS 12'h018
`define IDX_PHB_IGAIN 12'h020
`define IDX_PHB_MPGAIN0 12'h021
`define IDX_PHB_MPGAIN1 12'h022
`define IDX_PHB_MPGAIN2 12'h023
`define IDX_PHB_MPGAIN3 12'h024
`define IDX_PHB_MPGAIN4 12'h025
`define IDX_PHB_PHC0 12'h026
`define IDX_PHB_PHC1 12'h027
`define IDX_PHB_PHC2 12'h028
`define IDX_PHB_PHC3 12'h029
`define IDX_PHB_PHC4 12'h02A
`define IDX_PHB_VGAIN 12'h02B
`define IDX_PHB_IRMS_OS 12'h02C
`define IDX_PHB_VRMS_OS 12'h02D
`define IDX_PHB_PGAIN 12'h02E
`define IDX_PHB_WATT_OS 12'h02F
`define IDX_GSR 12'h0F0
`define IDX_LTHR0 12'h0F1
`define IDX_HTHR0 12'h0F5
`define IDX_HTHR3 12'h0F8
`define IDX_STATUS 12'h0F9

// ----------------------------------------------------------------
// Storage slots, fields and reset values
// ----------------------------------------------------------------
`define SLOT_PHB_BASE 12'h006
`define SLOT_GSR_BASE 12'h016
`define GSR_MULTIPOINT_ENABLE_BIT 0
`define GSR_WMASK 32'h00000001
`define STATUS_MULTIPOINT_ENABLE_BIT 4
`define CAL_RESET_VAL 32'h00000000

`endif

// ---- logic/calib_pkg.sv ----
// Types and address decode shared by the calibration bank
package calib_pkg;
`include "calib_consts.svh"

	typedef logic [`CAL_AW-1:0] cal_addr_t;
	typedef logic [`CAL_DW-1:0] cal_word_t;
	typedef logic [4:0] slot_t;
	typedef logic [2:0] range_idx_t;

	// State of the bank, apart from the range selector index and the gain stage registers
	typedef struct packed {
		logic [`CAL_NSLOT-1:0][`CAL_DW-1:0] cal;
		cal_word_t rdata;
		cal_word_t phase_comp;
		cal_word_t mp_gain;
		logic [7:0][`CAL_DW-1:0] rms;
	} bank_state_t;

	// Maps an index to {mapped, slot}
	function automatic logic [5:0] slot_of(input cal_addr_t a);
		logic [5:0] r;
		r = 6'h00;
		if (a >= `IDX_PHA_FIRMS_OS && a <= `IDX_PHA_MIRMS_OS) begin
			r = {1'b1, 5'(a - `IDX_PHA_FIRMS_OS)};
		end else if (a >= `IDX_PHB_IGAIN && a <= `IDX_PHB_WATT_OS) begin
			r = {1'b1, 5'(a - `IDX_PHB_IGAIN + `SLOT_PHB_BASE)};
		end else if (a >= `IDX_GSR && a <= `IDX_HTHR3) begin
			r = {1'b1, 5'(a - `IDX_GSR + `SLOT_GSR_BASE)};
		end
		return r;
	endfunction : slot_of

	// Storage slot of an index
	function automatic slot_t slot_num(input cal_addr_t a);
		logic [5:0] r;
		r = slot_of(a);
		return r[4:0];
	endfunction : slot_num
endpackage : calib_pkg

// ---- logic/gain_scaler.sv ----
// Registered gain and offset stage: y = x + x*gain/2^FRAC + offset
`timescale 1ns/100ps
`include "calib_consts.svh"
module gain_scaler #(
	parameter int W = `CAL_DW,
	parameter int FRAC = `GAIN_FRAC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sample and correction
	input wire logic [W-1:0] x,
	input wire logic [W-1:0] gain,
	input wire logic [W-1:0] offset,
	output logic [W-1:0] y
);
	typedef struct packed {
		logic [W-1:0] y;
	} scaler_state_t;

	scaler_state_t st_r;
	scaler_state_t st_nxt;
	logic signed [2*W-1:0] prod;

	// Zero gain and zero offset pass the sample through
	always_comb begin
		prod = $signed(x) * $signed(gain);
		st_nxt.y = x + prod[FRAC +: W] + offset;
		if (!rst_n) begin
			st_nxt.y = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign y = st_r.y;
endmodule : gain_scaler

// ---- logic/range_selector.sv ----
// Multipoint entry tracking with low/high threshold hysteresis
`timescale 1ns/100ps
`include "calib_consts.svh"
module range_selector #(
	parameter int W = `CAL_DW,
	parameter int N = `MP_ENTRIES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Current rms and thresholds, entry i to i+1
	input wire logic [W-1:0] rms,
	input wire logic [N-2:0][W-1:0] low_thr,
	input wire logic [N-2:0][W-1:0] high_thr,
	output logic [2:0] idx
);
	typedef struct packed {
		logic [2:0] idx;
	} range_state_t;

	range_state_t st_r;
	range_state_t st_nxt;

	// Step up above high, down below low, one entry a cycle
	always_comb begin
		st_nxt = st_r;
		if (!rst_n) begin
			st_nxt.idx = 3'h0;
		end else if (st_r.idx < 3'(N - 1) && rms > high_thr[st_r.idx]) begin
			st_nxt.idx = st_r.idx + 3'h1;
		end else if (st_r.idx != 3'h0 && rms < low_thr[st_r.idx - 3'h1]) begin
			st_nxt.idx = st_r.idx - 3'h1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign idx = st_r.idx;

	a_range_step_up: assert property (@(posedge clk) disable iff (!rst_n)
		(idx < 3'(N - 1) && rms > high_thr[idx])
		|=> idx == $past(idx) + 3'h1)
		else $error("range did not step up");
endmodule : range_selector

// ---- logic/calib_bank.sv ----
// Phase A/B calibration register bank with its correction datapath
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "calib_consts.svh"
module calib_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [`CAL_AW-1:0] addr,
	input wire logic [`CAL_DW-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [`CAL_DW-1:0] rdata,
	// Phase B channel samples
	input wire logic [`CAL_DW-1:0] phb_current_in,
	input wire logic [`CAL_DW-1:0] phb_voltage_in,
	output logic [`CAL_DW-1:0] phb_current_out,
	output logic [`CAL_DW-1:0] phb_voltage_out,
	output logic [`CAL_DW-1:0] phb_phase_comp,
	// Phase B rms, raw and corrected
	input wire logic [`CAL_DW-1:0] phb_current_rms_result,
	input wire logic [`CAL_DW-1:0] phb_voltage_rms_result,
	output logic [`CAL_DW-1:0] phb_current_rms_corr,
	output logic [`CAL_DW-1:0] phb_voltage_rms_corr,
	// Phase A rms, raw
	input wire logic [`CAL_DW-1:0] pha_fund_current_rms_raw,
	input wire logic [`CAL_DW-1:0] pha_fund_voltage_rms_raw,
	input wire logic [`CAL_DW-1:0] pha_halfcycle_voltage_rms_raw,
	input wire logic [`CAL_DW-1:0] pha_halfcycle_current_rms_raw,
	input wire logic [`CAL_DW-1:0] pha_multicycle_voltage_rms_raw,
	input wire logic [`CAL_DW-1:0] pha_multicycle_current_rms_raw,
	// Phase A rms, corrected
	output logic [`CAL_DW-1:0] pha_fund_current_rms,
	output logic [`CAL_DW-1:0] pha_fund_voltage_rms,
	output logic [`CAL_DW-1:0] pha_halfcycle_voltage_rms,
	output logic [`CAL_DW-1:0] pha_halfcycle_current_rms,
	output logic [`CAL_DW-1:0] pha_multicycle_voltage_rms,
	output logic [`CAL_DW-1:0] pha_multicycle_current_rms,
	// Phase B powers, raw
	input wire logic [`CAL_DW-1:0] phb_total_active_power_raw,
	input wire logic [`CAL_DW-1:0] phb_fund_active_power_raw,
	input wire logic [`CAL_DW-1:0] phb_total_reactive_power_raw,
	input wire logic [`CAL_DW-1:0] phb_fund_reactive_power_raw,
	input wire logic [`CAL_DW-1:0] phb_total_apparent_power_raw,
	input wire logic [`CAL_DW-1:0] phb_fund_apparent_power_raw,
	// Phase B powers, corrected
	output logic [`CAL_DW-1:0] phb_total_active_power,
	output logic [`CAL_DW-1:0] phb_fund_active_power,
	output logic [`CAL_DW-1:0] phb_total_reactive_power,
	output logic [`CAL_DW-1:0] phb_fund_reactive_power,
	output logic [`CAL_DW-1:0] phb_total_apparent_power,
	output logic [`CAL_DW-1:0] phb_fund_apparent_power
);
	// ----------------------------------------------------------------
	// Slot constants
	// ----------------------------------------------------------------
	localparam calib_pkg::slot_t S_PHA =
		calib_pkg::slot_num(`IDX_PHA_FIRMS_OS);
	localparam calib_pkg::slot_t S_IGAIN =
		calib_pkg::slot_num(`IDX_PHB_IGAIN);
	localparam calib_pkg::slot_t S_MPG0 =
		calib_pkg::slot_num(`IDX_PHB_MPGAIN0);
	localparam calib_pkg::slot_t S_PHC0 =
		calib_pkg::slot_num(`IDX_PHB_PHC0);
	localparam calib_pkg::slot_t S_VGAIN =
		calib_pkg::slot_num(`IDX_PHB_VGAIN);
	localparam calib_pkg::slot_t S_IRMS_OS =
		calib_pkg::slot_num(`IDX_PHB_IRMS_OS);
	localparam calib_pkg::slot_t S_VRMS_OS =
		calib_pkg::slot_num(`IDX_PHB_VRMS_OS);
	localparam calib_pkg::slot_t S_PGAIN =
		calib_pkg::slot_num(`IDX_PHB_PGAIN);
	localparam calib_pkg::slot_t S_WATT_OS =
		calib_pkg::slot_num(`IDX_PHB_WATT_OS);
	localparam calib_pkg::slot_t S_GSR =
		calib_pkg::slot_num(`IDX_GSR);
	localparam calib_pkg::slot_t S_LTHR0 =
		calib_pkg::slot_num(`IDX_LTHR0);
	localparam calib_pkg::slot_t S_HTHR0 =
		calib_pkg::slot_num(`IDX_HTHR0);
	localparam logic [`CAL_DW-1:0] UNITY_GAIN =
		`CAL_DW'(1) << `GAIN_FRAC;

	// ----------------------------------------------------------------
	// State and local wiring
	// ----------------------------------------------------------------
	calib_pkg::bank_state_t st_r;
	calib_pkg::bank_state_t st_nxt;
	calib_pkg::range_idx_t rng_idx;
	logic multipoint_enable;
	logic [`CAL_DW-1:0] cur_stage1;
	logic [5:0][`CAL_DW-1:0] pha_raw;
	logic [5:0][`CAL_DW-1:0] pw_raw;
	logic [5:0][`CAL_DW-1:0] pw_out;

	assign multipoint_enable = st_r.cal[S_GSR][`GSR_MULTIPOINT_ENABLE_BIT];

	// Phase A raw rms in slot order
	assign pha_raw[0] = pha_fund_current_rms_raw;
	assign pha_raw[1] = pha_fund_voltage_rms_raw;
	assign pha_raw[2] = pha_halfcycle_voltage_rms_raw;
	assign pha_raw[3] = pha_halfcycle_current_rms_raw;
	assign pha_raw[4] = pha_multicycle_voltage_rms_raw;
	assign pha_raw[5] = pha_multicycle_current_rms_raw;

	// Powers, total active first so it alone takes the offset
	assign pw_raw[0] = phb_total_active_power_raw;
	assign pw_raw[1] = phb_fund_active_power_raw;
	assign pw_raw[2] = phb_total_reactive_power_raw;
	assign pw_raw[3] = phb_fund_reactive_power_raw;
	assign pw_raw[4] = phb_total_apparent_power_raw;
	assign pw_raw[5] = phb_fund_apparent_power_raw;

	// ----------------------------------------------------------------
	// Register file, selection and rms offsets
	// ----------------------------------------------------------------
	always_comb begin
		logic hit;
		calib_pkg::slot_t slot;
		logic [`CAL_DW-1:0] wmask;
		hit = 1'b0;
		slot = '0;
		wmask = '1;
		st_nxt = st_r;
		st_nxt.rdata = '0;
		{hit, slot} = calib_pkg::slot_of(addr);
		if (slot == S_GSR) begin
			wmask = `GSR_WMASK;
		end
		// Write: unmapped indices are dropped
		if (wr_stb && hit) begin
			st_nxt.cal[slot] = wdata & wmask;
		end
		// Read: data stands only in the following cycle
		if (rd_stb && hit) begin
			st_nxt.rdata = st_r.cal[slot];
		end else if (rd_stb && addr == `IDX_STATUS) begin
			st_nxt.rdata[2:0] = rng_idx;
			st_nxt.rdata[`STATUS_MULTIPOINT_ENABLE_BIT] = multipoint_enable;
		end
		// Multipoint gain entry, zero when single point
		if (multipoint_enable) begin
			st_nxt.mp_gain = st_r.cal[S_MPG0 + 5'(rng_idx)];
		end else begin
			st_nxt.mp_gain = '0;
		end
		// Phase compensation entry
		if (multipoint_enable) begin
			st_nxt.phase_comp = st_r.cal[S_PHC0 + 5'(rng_idx)];
		end else begin
			st_nxt.phase_comp = st_r.cal[S_PHC0];
		end
		// Phase A offsets: fundamental, half-cycle, 10/12-cycle
		st_nxt.rms[0] = pha_raw[0] + st_r.cal[S_PHA];
		st_nxt.rms[1] = pha_raw[1] + st_r.cal[S_PHA + 5'h1];
		st_nxt.rms[2] = pha_raw[2] + st_r.cal[S_PHA + 5'h2];
		st_nxt.rms[3] = pha_raw[3] + st_r.cal[S_PHA + 5'h3];
		st_nxt.rms[4] = pha_raw[4] + st_r.cal[S_PHA + 5'h4];
		st_nxt.rms[5] = pha_raw[5] + st_r.cal[S_PHA + 5'h5];
		// Phase B offsets
		st_nxt.rms[6] = phb_current_rms_result + st_r.cal[S_IRMS_OS];
		st_nxt.rms[7] = phb_voltage_rms_result + st_r.cal[S_VRMS_OS];
		// Reset leaves every correction at zero
		if (!rst_n) begin
			for (int i = 0; i < `CAL_NSLOT; i++) begin
				st_nxt.cal[i] = `CAL_RESET_VAL;
			end
			st_nxt.rdata = '0;
			st_nxt.mp_gain = '0;
			st_nxt.phase_comp = '0;
			st_nxt.rms = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Multipoint entry selection on corrected current rms
	// ----------------------------------------------------------------
	range_selector #(
		.W(`CAL_DW),
		.N(`MP_ENTRIES)
	) u_range (
		.clk(clk),
		.rst_n(rst_n),
		.rms(st_r.rms[6]),
		.low_thr(st_r.cal[S_LTHR0 +: `MP_ENTRIES - 1]),
		.high_thr(st_r.cal[S_HTHR0 +: `MP_ENTRIES - 1]),
		.idx(rng_idx)
	);

	// ----------------------------------------------------------------
	// Channel gains
	// ----------------------------------------------------------------
	// Current: base gain, then the multipoint gain entry
	gain_scaler u_cur_gain (
		.clk(clk),
		.rst_n(rst_n),
		.x(phb_current_in),
		.gain(st_r.cal[S_IGAIN]),
		.offset('0),
		.y(cur_stage1)
	);

	gain_scaler u_cur_mp (
		.clk(clk),
		.rst_n(rst_n),
		.x(cur_stage1),
		.gain(st_r.mp_gain),
		.offset('0),
		.y(phb_current_out)
	);

	// Voltage gain
	gain_scaler u_volt_gain (
		.clk(clk),
		.rst_n(rst_n),
		.x(phb_voltage_in),
		.gain(st_r.cal[S_VGAIN]),
		.offset('0),
		.y(phb_voltage_out)
	);

	// Power gain on all six results, offset on total active
	for (genvar g = 0; g < 6; g++) begin : g_pw
		gain_scaler u_pw (
			.clk(clk),
			.rst_n(rst_n),
			.x(pw_raw[g]),
			.gain(st_r.cal[S_PGAIN]),
			.offset(g == 0 ? st_r.cal[S_WATT_OS] : '0),
			.y(pw_out[g])
		);
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata = st_r.rdata;
	assign phb_phase_comp = st_r.phase_comp;
	assign pha_fund_current_rms = st_r.rms[0];
	assign pha_fund_voltage_rms = st_r.rms[1];
	assign pha_halfcycle_voltage_rms = st_r.rms[2];
	assign pha_halfcycle_current_rms = st_r.rms[3];
	assign pha_multicycle_voltage_rms = st_r.rms[4];
	assign pha_multicycle_current_rms = st_r.rms[5];
	assign phb_current_rms_corr = st_r.rms[6];
	assign phb_voltage_rms_corr = st_r.rms[7];
	assign phb_total_active_power = pw_out[0];
	assign phb_fund_active_power = pw_out[1];
	assign phb_total_reactive_power = pw_out[2];
	assign phb_fund_reactive_power = pw_out[3];
	assign phb_total_apparent_power = pw_out[4];
	assign phb_fund_apparent_power = pw_out[5];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Read data is zero unless a read came one cycle before
	a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(rd_stb) |-> rdata == '0)
		else $error("read data outside its cycle");

	// Written voltage gain reads back
	a_vgain_readback: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_stb && addr == `IDX_PHB_VGAIN) ##1
		(rd_stb && addr == `IDX_PHB_VGAIN) |=>
		rdata == $past(wdata, 2))
		else $error("voltage gain readback mismatch");

	// Unity extra voltage gain doubles the sample
	a_vgain_unity: assert property (@(posedge clk) disable iff (!rst_n)
		$past(st_r.cal[S_VGAIN]) == UNITY_GAIN |->
		phb_voltage_out == `CAL_DW'($past(phb_voltage_in) << 1))
		else $error("voltage gain not applied");

	// Zero gains leave the current two cycles late and untouched
	a_cur_zero_gain: assert property (@(posedge clk) disable iff (!rst_n)
		($past(rst_n) && $past(rst_n, 2) &&
		$past(st_r.cal[S_IGAIN], 2) == '0 && $past(st_r.mp_gain) == '0)
		|-> phb_current_out == $past(phb_current_in, 2))
		else $error("zero current gain altered sample");

	// Single point uses phase entry zero
	a_phase_single: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(multipoint_enable) |-> phb_phase_comp == $past(st_r.cal[S_PHC0]))
		else $error("single point phase entry wrong");

	// Multipoint phase entry follows the range index
	a_phase_multi: assert property (@(posedge clk) disable iff (!rst_n)
		(multipoint_enable && rng_idx == 3'h3) |=>
		phb_phase_comp == $past(st_r.cal[S_PHC0 + 5'h3]))
		else $error("multipoint phase entry wrong");

	// Multipoint gain entry follows the range index
	a_mp_gain_sel: assert property (@(posedge clk) disable iff (!rst_n)
		(multipoint_enable && rng_idx == 3'h4) |=>
		st_r.mp_gain == $past(st_r.cal[S_MPG0 + 5'h4]))
		else $error("multipoint gain entry wrong");

	// Offset on total active power with zero power gain
	a_watt_offset: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(st_r.cal[S_PGAIN]) == '0 |->
		phb_total_active_power == `CAL_DW'($past(pw_raw[0]) +
		$past(st_r.cal[S_WATT_OS])))
		else $error("active power offset wrong");

	// Unity power gain doubles fundamental reactive power
	a_pgain_unity: assert property (@(posedge clk) disable iff (!rst_n)
		$past(st_r.cal[S_PGAIN]) == UNITY_GAIN |->
		phb_fund_reactive_power == `CAL_DW'($past(pw_raw[3]) << 1))
		else $error("power gain not applied");

	// Phase B current rms offset
	a_phb_irms_os: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> phb_current_rms_corr ==
		`CAL_DW'($past(phb_current_rms_result) +
		$past(st_r.cal[S_IRMS_OS])))
		else $error("current rms offset wrong");

	// Phase A fundamental voltage rms offset
	a_pha_fvrms_os: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> pha_fund_voltage_rms ==
		`CAL_DW'($past(pha_fund_voltage_rms_raw) +
		$past(st_r.cal[S_PHA + 5'h1])))
		else $error("fundamental voltage rms offset wrong");

	// Phase A 10/12-cycle current rms offset
	a_pha_mirms_os: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> pha_multicycle_current_rms ==
		`CAL_DW'($past(pha_multicycle_current_rms_raw) +
		$past(st_r.cal[S_PHA + 5'h5])))
		else $error("multicycle current rms offset wrong");
endmodule : calib_bank

// ---- tb/calib_bank_tb.sv ----
// Self-checking testbench for the calibration register bank
`timescale 1ns/100ps
`include "calib_consts.svh"
module calib_bank_tb;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	calib_pkg::cal_addr_t addr = 12'h000;
	calib_pkg::cal_word_t wdata = 32'h00000000;
	calib_pkg::cal_word_t phb_current_in = 32'h00001000;
	calib_pkg::cal_word_t phb_voltage_in = 32'h00001000;
	calib_pkg::cal_word_t phb_current_rms_result = 32'h00000030;
	calib_pkg::cal_word_t phb_voltage_rms_result = 32'h00000500;
	calib_pkg::cal_word_t pha_fund_current_rms_raw = 32'h00001000;
	calib_pkg::cal_word_t pha_fund_voltage_rms_raw = 32'h00002000;
	calib_pkg::cal_word_t pha_halfcycle_voltage_rms_raw = 32'h00003000;
	calib_pkg::cal_word_t pha_halfcycle_current_rms_raw = 32'h00004000;
	calib_pkg::cal_word_t pha_multicycle_voltage_rms_raw = 32'h00005000;
	calib_pkg::cal_word_t pha_multicycle_current_rms_raw = 32'h00006000;
	calib_pkg::cal_word_t phb_total_active_power_raw = 32'h00002000;
	calib_pkg::cal_word_t phb_fund_active_power_raw = 32'h00004000;
	calib_pkg::cal_word_t phb_total_reactive_power_raw = 32'h00006000;
	calib_pkg::cal_word_t phb_fund_reactive_power_raw = 32'h00008000;
	calib_pkg::cal_word_t phb_total_apparent_power_raw = 32'h0000A000;
	calib_pkg::cal_word_t phb_fund_apparent_power_raw = 32'h0000C000;
	calib_pkg::cal_word_t rdata, phb_current_out, phb_voltage_out;
	calib_pkg::cal_word_t phb_phase_comp, phb_current_rms_corr;
	calib_pkg::cal_word_t phb_voltage_rms_corr, pha_fund_current_rms;
	calib_pkg::cal_word_t pha_fund_voltage_rms, pha_halfcycle_voltage_rms;
	calib_pkg::cal_word_t pha_halfcycle_current_rms;
	calib_pkg::cal_word_t pha_multicycle_voltage_rms;
	calib_pkg::cal_word_t pha_multicycle_current_rms;
	calib_pkg::cal_word_t phb_total_active_power, phb_fund_active_power;
	calib_pkg::cal_word_t phb_total_reactive_power, phb_fund_reactive_power;
	calib_pkg::cal_word_t phb_total_apparent_power, phb_fund_apparent_power;
	int num_errors = 0;
	int samples_checked = 0;
	// Values written to the 22 registers; gains of 0x04000000 mean x1.5
	calib_pkg::cal_word_t vals [22] = '{32'h00000010, 32'h00000020,
		32'h00000030, 32'h00000040, 32'h00000050, 32'h00000060,
		32'h04000000, 32'h00000000, 32'h01000000, 32'h02000000,
		32'h03000000, 32'h04000000, 32'h00000A00, 32'h00000A01,
		32'h00000A02, 32'h00000A03, 32'h00000A04, 32'h04000000,
		32'h00000020, 32'h00000030, 32'h04000000, 32'h00000010};

	// ----------------------------------------------------------------
	// Design, clock and watchdog
	// ----------------------------------------------------------------
	calib_bank i_dut (.*);

	// Clock of 20 ns
	always #10 clk = ~clk;

	// Cuts a hung run short
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Index of register slot i: Phase A block, then Phase B block
	function automatic calib_pkg::cal_addr_t reg_addr(input int i);
		return (i < 6) ? 12'h013 + 12'(i) : 12'h01A + 12'(i);
	endfunction : reg_addr

	task automatic chk(input calib_pkg::cal_word_t got, exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// One-cycle write strobe
	task automatic wr(input calib_pkg::cal_addr_t a,
		input calib_pkg::cal_word_t d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data stands in the following cycle only
	task automatic rd(input calib_pkg::cal_addr_t a,
		input calib_pkg::cal_word_t exp);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd

	// Whole datapath with corrections off (c=0) or as in vals (c=1)
	task automatic check_all(input bit c);
		calib_pkg::cal_word_t m;
		m = {32{c}};
		#1;
		chk(pha_fund_current_rms, 32'h00001000 + (vals[0] & m));
		chk(pha_fund_voltage_rms, 32'h00002000 + (vals[1] & m));
		chk(pha_halfcycle_voltage_rms, 32'h00003000 + (vals[2] & m));
		chk(pha_halfcycle_current_rms, 32'h00004000 + (vals[3] & m));
		chk(pha_multicycle_voltage_rms, 32'h00005000 + (vals[4] & m));
		chk(pha_multicycle_current_rms, 32'h00006000 + (vals[5] & m));
		chk(phb_current_rms_corr, 32'h00000030 + (vals[18] & m));
		chk(phb_voltage_rms_corr, 32'h00000500 + (vals[19] & m));
		chk(phb_voltage_out, 32'h00001000 + (32'h00000800 & m));
		chk(phb_current_out, 32'h00001000 + (32'h00000800 & m));
		chk(phb_phase_comp, vals[12] & m);
		chk(phb_total_active_power, 32'h00002000 + (32'h00001010 & m));
		chk(phb_fund_active_power, 32'h00004000 + (32'h00002000 & m));
		chk(phb_total_reactive_power, 32'h00006000 + (32'h00003000 & m));
		chk(phb_fund_reactive_power, 32'h00008000 + (32'h00004000 & m));
		chk(phb_total_apparent_power, 32'h0000A000 + (32'h00005000 & m));
		chk(phb_fund_apparent_power, 32'h0000C000 + (32'h00006000 & m));
	endtask : check_all

	task automatic report_and_stop;
		$display("Mismatches %0d of %0d checks", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		tick(6);
		rst_n <= 1'b1;
		tick(3);
		check_all(1'b0);
		for (int i = 0; i < 22; i++) begin
			rd(reg_addr(i), 32'h00000000);
		end
		// Each register written then read back
		for (int i = 0; i < 22; i++) begin
			wr(reg_addr(i), vals[i]);
			rd(reg_addr(i), vals[i]);
		end
		tick(1);
		#1;
		chk(rdata, 32'h00000000);
		tick(3);
		check_all(1'b1);
		// Unmapped index: read 0, write lost
		wr(12'h019, 32'hFFFFFFFF);
		rd(12'h019, 32'h00000000);
		// Thresholds: low i = 0x80*(i+1), high i = 0x100*(i+1)
		for (int i = 0; i < 4; i++) begin
			wr(`IDX_LTHR0 + 12'(i), 32'(i + 1) * 32'h00000080);
			wr(`IDX_HTHR0 + 12'(i), 32'(i + 1) * 32'h00000100);
		end
		// Disabled: entry tracks to 4 but compensation stays on entry 0
		@(posedge clk);
		phb_current_rms_result <= 32'h00000430;
		tick(8);
		chk(phb_phase_comp, vals[12]);
		chk(phb_current_out, 32'h00001800);
		rd(`IDX_STATUS, 32'h00000004);
		wr(`IDX_GSR, 32'hFFFFFFFF);
		rd(`IDX_GSR, 32'h00000001);
		wr(`IDX_STATUS, 32'h00000000);
		rd(`IDX_STATUS, 32'h00000014);
		@(posedge clk);
		phb_current_rms_result <= 32'h00000030;
		tick(8);
		// Climb through every entry
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			phb_current_rms_result <= 32'(k) * 32'h00000100 + 32'h00000030;
			tick(8);
			chk(phb_phase_comp, vals[12 + k]);
			chk(phb_current_out, 32'h00001800 + 32'(k) * 32'h00000300);
			rd(`IDX_STATUS, 32'h00000010 | 32'(k));
		end
		// Between low and high bounds the entry holds
		@(posedge clk);
		phb_current_rms_result <= 32'h00000380;
		tick(8);
		rd(`IDX_STATUS, 32'h00000014);
		wr(`IDX_GSR, 32'h00000000);
		tick(4);
		chk(phb_phase_comp, vals[12]);
		chk(phb_current_out, 32'h00001800);
		// Unity gains double the samples; write then read back to back
		@(posedge clk);
		wr_stb <= 1'b1;
		addr <= `IDX_PHB_VGAIN;
		wdata <= 32'h08000000;
		@(posedge clk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		chk(rdata, 32'h08000000);
		wr(`IDX_PHB_PGAIN, 32'h08000000);
		tick(3);
		#1;
		chk(phb_voltage_out, 32'h00002000);
		chk(phb_fund_reactive_power, 32'h00010000);
		report_and_stop();
	end
endmodule : calib_bank_tb
